//--- bench/tb_usw_path_switch.sv
// Self-checking bench for the connector path switch pin logic.
`timescale 1ns/1ps
`default_nettype none

module tb_usw_path_switch;
  // ****************************************************************
  // Stimulus, instances and helpers
  // ****************************************************************
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic clk_en = 1'h1;
  logic id_pin = 1'h0;
  logic supply_pin = 1'h0;
  logic [1:0] acc_kind = 2'h0;
  logic boot_req = 1'h0;
  logic manual_mode = 1'h0;
  logic [1:0] manual_route = 2'h0;
  logic int_mask = 1'h1;
  logic r_usb, r_uart, r_sec, flag_out, flag_oe, boot_sel, irq_n;
  logic sda_out, sda_oe, hi_out, hi_oe, scl, sda_low, ack;
  logic [7:0] rd;
  wire logic sda_line;
  int error_cnt = 0;
  int checked = 0;
  logic [7:0] auto_exp [4] = '{8'h00, 8'h04, 8'h04, 8'h01};
  logic [7:0] man_exp [4] = '{8'h00, 8'h04, 8'h02, 8'h01};

  // Clock at 100 MHz.
  always #5 sys_clk = ~sys_clk;

  // Open-drain data line with a pull-up: low while either party pulls.
  assign sda_line = !(sda_low || (sda_oe && !sda_out));

  usw_path_switch i_dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .clk_en(clk_en), .connector_id_line(id_pin),
    .connector_supply_sense(supply_pin), .acc_kind(acc_kind),
    .factory_boot_req(boot_req), .manual_mode(manual_mode),
    .manual_route(manual_route), .int_mask(int_mask),
    .route_primary_usb(r_usb), .route_primary_uart(r_uart),
    .route_secondary(r_sec), .factory_cable_flag_out(flag_out),
    .factory_cable_flag_oe(flag_oe), .boot_sel_out(boot_sel),
    .irq_n_out(irq_n), .i2c_scl_in(scl), .i2c_sda_in(sda_line),
    .i2c_sda_out(sda_out), .i2c_sda_oe(sda_oe));

  // Push-pull build of the factory flag, watched for its flag only.
  usw_path_switch #(.FACTORY_ACTIVE_LOW(1'h0)) i_dut_hi (.sys_clk(sys_clk),
    .reset_n(reset_n), .clk_en(clk_en), .connector_id_line(id_pin),
    .connector_supply_sense(supply_pin), .acc_kind(acc_kind),
    .factory_boot_req(boot_req), .manual_mode(manual_mode),
    .manual_route(manual_route), .int_mask(int_mask),
    .route_primary_usb(), .route_primary_uart(), .route_secondary(),
    .factory_cable_flag_out(hi_out), .factory_cable_flag_oe(hi_oe),
    .boot_sel_out(), .irq_n_out(), .i2c_scl_in(scl),
    .i2c_sda_in(sda_line), .i2c_sda_out(), .i2c_sda_oe());

  usw_i2c_master i_master (.sys_clk(sys_clk), .sda_line(sda_line),
    .scl(scl), .sda_low(sda_low));

  // Counts a comparison and reports a mismatch at once.
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Lets n rising edges pass and stops where outputs have settled.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : tick

  // Route enables packed as usb, uart, secondary.
  function automatic logic [7:0] routes();
    return {5'h00, r_usb, r_uart, r_sec};
  endfunction : routes

  // Expected status byte with the pending flag set.
  function automatic logic [7:0] status_exp(logic [1:0] k, logic id);
    logic [7:0] s;
    s = 8'h00;
    s[usw_pkg::USW_ST_KIND_HI -: 2] = k;
    s[usw_pkg::USW_ST_ID] = id;
    s[usw_pkg::USW_ST_PENDING] = 1'h1;
    return s;
  endfunction : status_exp

  // Reads one status byte, ending with a not-acknowledge and a stop.
  task automatic read_status();
    i_master.start();
    i_master.send({usw_pkg::USW_TGT_ADDR, 1'h1}, ack);
    i_master.recv(1'h0, rd);
    i_master.stop();
  endtask : read_status

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Levels while reset is held and just after release.
  task automatic test_reset();
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    check("rst_routes", routes(), 8'h00);
    check("rst_boot", boot_sel, 8'h00);
    check("rst_irq_n", irq_n, 8'h01);
    check("rst_flag_oe", flag_oe, 8'h00);
    check("rst_hi_flag", {hi_oe, hi_out}, 8'h02);
    @(posedge sys_clk);
    reset_n <= 1'h1;
    tick(4);
    check("open_routes", routes(), 8'h00);
  endtask : test_reset

  // Automatic routing and factory outputs for every accessory kind.
  task automatic test_auto();
    logic fac;
    for (int k = 0; k < 4; k++) begin
      for (int b = 0; b < 2; b++) begin
        @(posedge sys_clk);
        acc_kind <= 2'(k);
        boot_req <= 1'(b);
        tick(2);
        fac = (k >= 2);
        check("auto_routes", routes(), auto_exp[k]);
        check("flag_lo", {flag_oe, flag_out}, {fac, 1'h0});
        check("flag_hi", {hi_oe, hi_out}, {1'h1, fac});
        check("boot_sel", boot_sel, fac & b[0]);
      end
    end
  endtask : test_auto

  // Every manual route, then a frozen clock enable.
  task automatic test_manual();
    @(posedge sys_clk);
    manual_mode <= 1'h1;
    for (int r = 0; r < 4; r++) begin
      @(posedge sys_clk);
      manual_route <= 2'(r);
      tick(2);
      check("man_routes", routes(), man_exp[r]);
    end
    @(posedge sys_clk);
    clk_en <= 1'h0;
    manual_route <= 2'h1;
    tick(3);
    check("frozen", routes(), 8'h01);
    @(posedge sys_clk);
    clk_en <= 1'h1;
    tick(2);
    check("thawed", routes(), 8'h04);
    @(posedge sys_clk);
    manual_mode <= 1'h0;
  endtask : test_manual

  // Masked and unmasked interrupts, status reads and address match.
  task automatic test_irq();
    @(posedge sys_clk);
    acc_kind <= 2'h0;
    tick(3);
    read_status();
    @(posedge sys_clk);
    acc_kind <= 2'h1;
    tick(10);
    check("masked_irq", irq_n, 8'h01);
    @(posedge sys_clk);
    int_mask <= 1'h0;
    tick(2);
    check("unmask_irq", irq_n, 8'h00);
    read_status();
    check("rd_ack", ack, 8'h01);
    check("status", rd, status_exp(2'h1, 1'h0));
    tick(3);
    check("irq_clear", irq_n, 8'h01);
    @(posedge sys_clk);
    id_pin <= 1'h1;
    tick(8);
    check("id_irq", irq_n, 8'h00);
    read_status();
    check("status_id", rd, status_exp(2'h1, 1'h1));
    i_master.start();
    i_master.send({usw_pkg::USW_TGT_ADDR ^ 7'h01, 1'h1}, ack);
    i_master.stop();
    check("bad_addr", ack, 8'h00);
    i_master.start();
    i_master.send({usw_pkg::USW_TGT_ADDR, 1'h0}, ack);
    check("wr_addr", ack, 8'h01);
    i_master.send(8'h5A, ack);
    i_master.stop();
    check("wr_data", ack, 8'h01);
  endtask : test_irq

  // Main sequence.
  initial begin
    test_reset();
    test_auto();
    test_manual();
    test_irq();
    final_report();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    $display("[ERR] watchdog expected done seen timeout");
    final_report();
  end
endmodule : tb_usw_path_switch

`default_nettype wire

//--- bench/usw_i2c_master.sv
// Serial bus master model standing in for the baseband processor.
`timescale 1ns/1ps
`default_nettype none

module usw_i2c_master (
  // Clock.
  input wire logic sys_clk,
  // Bus lines.
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  // ****************************************************************
  // Bus phases
  // ****************************************************************
  // The bus idles released, with both lines pulled high.
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end

  // A third of a bit period, long enough for the target's pin filters.
  task automatic half();
    repeat (10) @(posedge sys_clk);
  endtask : half

  // Start condition: data falls while the clock is high.
  task automatic start();
    sda_low <= 1'h0;
    scl <= 1'h1;
    half();
    sda_low <= 1'h1;
    half();
    scl <= 1'h0;
  endtask : start

  // Stop condition: data rises while the clock is high.
  task automatic stop();
    half();
    sda_low <= 1'h1;
    half();
    scl <= 1'h1;
    half();
    sda_low <= 1'h0;
    half();
  endtask : stop

  // One bit: data moves only while the clock is low, sampled before it falls.
  task automatic bit_xfer(input logic tx, output logic rx);
    half();
    sda_low <= !tx;
    half();
    scl <= 1'h1;
    half();
    rx = sda_line;
    scl <= 1'h0;
  endtask : bit_xfer

  // Sends a byte MSB first and returns the target's acknowledge.
  task automatic send(input logic [7:0] b, output logic ack);
    logic rx;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(b[i], rx);
    end
    bit_xfer(1'h1, rx);
    ack = !rx;
  endtask : send

  // Receives a byte MSB first, then acknowledges or not.
  task automatic recv(input logic ack_out, output logic [7:0] b);
    logic rx;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'h1, rx);
      b[i] = rx;
    end
    bit_xfer(!ack_out, rx);
  endtask : recv
endmodule : usw_i2c_master

`default_nettype wire

//--- include/usw_pkg.sv
// Shared constants and types for the connector path switch pin logic.
package usw_pkg;

  // ****************************************************************
  // Accessory kinds and manual route codes
  // ****************************************************************
  typedef enum logic [1:0] {
    USW_ACC_NONE,
    USW_ACC_USB,
    USW_ACC_USB_FACTORY,
    USW_ACC_UART_FACTORY
  } usw_acc_t;

  typedef enum logic [1:0] {
    USW_RT_OPEN,
    USW_RT_PRI_USB,
    USW_RT_PRI_UART,
    USW_RT_SECONDARY
  } usw_route_t;

  // ****************************************************************
  // Serial target phases and constants
  // ****************************************************************
  typedef enum logic [2:0] {
    USW_IDLE,
    USW_ADDR,
    USW_ACK_ADDR,
    USW_WDATA,
    USW_ACK_WDATA,
    USW_RDATA,
    USW_RACK
  } usw_i2c_t;

  localparam logic [6:0] USW_TGT_ADDR = 7'h25;
  localparam logic [3:0] USW_BITS_BYTE = 4'h8;
  localparam logic [3:0] USW_BIT_ONE = 4'h1;
  localparam logic [3:0] USW_BIT_ZERO = 4'h0;
  localparam logic [7:0] USW_BYTE_ZERO = 8'h00;
  localparam logic USW_SDA_LOW = 1'b0;

  // ****************************************************************
  // Status byte layout
  // ****************************************************************
  localparam int USW_ST_KIND_HI = 7;
  localparam int USW_ST_KIND_LO = 6;
  localparam int USW_ST_ID = 5;
  localparam int USW_ST_SUPPLY = 4;
  localparam int USW_ST_PENDING = 0;
  localparam logic [2:0] USW_ST_RSVD = 3'h0;

endpackage : usw_pkg

//--- verilog/usw_path_switch.sv
// Connector path switch: routing, factory outputs, interrupt, target.
// Functional notes
// - After reset every connector-to-host path stays open until selected.
// - Connector D+ goes to primary D+ or primary receive line by mode.
// - Connector D- goes to primary D- or primary transmit line by mode.
// - USB accessory or USB factory cable routes to primary pair by default.
// - UART factory cable routes to secondary pair by default.
// - The connector ID line is the input for accessory detection.
// - Factory flag is open-drain active low or push-pull active high.
// - Boot-select output is push-pull and low after reset.
// - Interrupt goes low when ID status or attach status changes.
// - Device is a serial target on input clock and open-drain data.
// - Interrupt stays masked while the mask bit is set.
`timescale 1ns/1ps
`default_nettype none

module usw_path_switch #(
  parameter bit FACTORY_ACTIVE_LOW = 1'b1,
  parameter logic [6:0] TGT_ADDR = usw_pkg::USW_TGT_ADDR
) (
  // Clock, reset and enable.
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Connector pins and detector result.
  input wire logic connector_id_line,
  input wire logic connector_supply_sense,
  input wire logic [1:0] acc_kind,
  input wire logic factory_boot_req,
  // Configuration levels.
  input wire logic manual_mode,
  input wire logic [1:0] manual_route,
  input wire logic int_mask,
  // Switch enables.
  output logic route_primary_usb,
  output logic route_primary_uart,
  output logic route_secondary,
  // Factory outputs.
  output logic factory_cable_flag_out,
  output logic factory_cable_flag_oe,
  output logic boot_sel_out,
  // Processor interface.
  output logic irq_n_out,
  input wire logic i2c_scl_in,
  input wire logic i2c_sda_in,
  output logic i2c_sda_out,
  output logic i2c_sda_oe
);

  typedef struct packed {
    usw_pkg::usw_i2c_t phase;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic sda_oe;
    logic scl_q;
    logic sda_q;
    logic id_q;
    logic att_q;
    logic pending;
    logic r_pusb;
    logic r_puart;
    logic r_sec;
    logic fac_o;
    logic fac_oe;
    logic boot;
    logic irq_n;
  } usw_state_t;

  usw_state_t st_r;
  usw_state_t st_nxt;
  logic [3:0] pins_f;
  logic scl_f;
  logic sda_f;
  logic id_f;
  logic sup_f;
  logic attached;
  logic factory;
  logic start_c;
  logic stop_c;
  logic scl_rise;
  logic scl_fall;
  logic rd_done;
  usw_pkg::usw_route_t route_sel;
  logic [7:0] status_byte;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Serial lines idle high, so they leave reset at one.
  usw_pin_sync #(
    .W(4),
    .RST_VAL(4'h3)
  ) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin_raw({connector_supply_sense, connector_id_line, i2c_sda_in,
              i2c_scl_in}),
    .pin_filt(pins_f)
  );

  assign scl_f = pins_f[0];
  assign sda_f = pins_f[1];
  assign id_f = pins_f[2];
  assign sup_f = pins_f[3];

  // ****************************************************************
  // Route selection
  // ****************************************************************
  // Automatic mode follows the detected kind; manual mode takes the code.
  always_comb begin
    route_sel = usw_pkg::USW_RT_OPEN;
    if (manual_mode) begin
      route_sel = usw_pkg::usw_route_t'(manual_route);
    end else begin
      unique case (usw_pkg::usw_acc_t'(acc_kind))
        usw_pkg::USW_ACC_NONE: route_sel = usw_pkg::USW_RT_OPEN;
        usw_pkg::USW_ACC_USB: route_sel = usw_pkg::USW_RT_PRI_USB;
        usw_pkg::USW_ACC_USB_FACTORY: begin
          route_sel = usw_pkg::USW_RT_PRI_USB;
        end
        usw_pkg::USW_ACC_UART_FACTORY: begin
          route_sel = usw_pkg::USW_RT_SECONDARY;
        end
      endcase
    end
  end

  // Detection status seen by the interrupt and the status byte.
  assign attached = (acc_kind != usw_pkg::USW_ACC_NONE) || sup_f;
  assign factory = (acc_kind == usw_pkg::USW_ACC_USB_FACTORY) ||
                   (acc_kind == usw_pkg::USW_ACC_UART_FACTORY);
  assign status_byte = {acc_kind, id_f, sup_f, usw_pkg::USW_ST_RSVD,
                        st_r.pending};

  // Serial bus events, taken from the filtered lines.
  assign start_c = scl_f && st_r.scl_q && st_r.sda_q && !sda_f;
  assign stop_c = scl_f && st_r.scl_q && !st_r.sda_q && sda_f;
  assign scl_rise = scl_f && !st_r.scl_q;
  assign scl_fall = !scl_f && st_r.scl_q;
  assign rd_done = scl_fall && (st_r.phase == usw_pkg::USW_RDATA) &&
                   (st_r.bitcnt == usw_pkg::USW_BITS_BYTE);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.scl_q = scl_f;
    st_nxt.sda_q = sda_f;
    st_nxt.id_q = id_f;
    st_nxt.att_q = attached;
    // At most one decoded enable can be high for any route code.
    st_nxt.r_pusb = (route_sel == usw_pkg::USW_RT_PRI_USB);
    st_nxt.r_puart = (route_sel == usw_pkg::USW_RT_PRI_UART);
    st_nxt.r_sec = (route_sel == usw_pkg::USW_RT_SECONDARY);
    // Factory flag drive depends on the build variant.
    if (FACTORY_ACTIVE_LOW) begin
      st_nxt.fac_o = 1'b0;
      st_nxt.fac_oe = factory;
    end else begin
      st_nxt.fac_o = factory;
      st_nxt.fac_oe = 1'b1;
    end
    st_nxt.boot = factory && factory_boot_req;
    // A status read clears the pending flag; a new change wins over it.
    if (rd_done) begin
      st_nxt.pending = 1'b0;
    end
    if ((id_f != st_r.id_q) || (attached != st_r.att_q)) begin
      st_nxt.pending = 1'b1;
    end
    st_nxt.irq_n = !(st_nxt.pending && !int_mask);
    // Serial target: address match, write acknowledge, status read.
    if (start_c) begin
      st_nxt.phase = usw_pkg::USW_ADDR;
      st_nxt.bitcnt = usw_pkg::USW_BIT_ZERO;
      st_nxt.sda_oe = 1'b0;
    end else if (stop_c) begin
      st_nxt.phase = usw_pkg::USW_IDLE;
      st_nxt.sda_oe = 1'b0;
    end else if (scl_rise) begin
      unique case (st_r.phase)
        usw_pkg::USW_ADDR, usw_pkg::USW_WDATA: begin
          st_nxt.shreg = {st_r.shreg[6:0], sda_f};
          st_nxt.bitcnt = st_r.bitcnt + usw_pkg::USW_BIT_ONE;
        end
        usw_pkg::USW_RDATA: st_nxt.bitcnt = st_r.bitcnt + usw_pkg::USW_BIT_ONE;
        usw_pkg::USW_RACK: begin
          if (sda_f) begin
            st_nxt.phase = usw_pkg::USW_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (st_r.phase)
        usw_pkg::USW_ADDR: begin
          if (st_r.bitcnt == usw_pkg::USW_BITS_BYTE) begin
            if (st_r.shreg[7:1] == TGT_ADDR) begin
              st_nxt.phase = usw_pkg::USW_ACK_ADDR;
              st_nxt.sda_oe = 1'b1;
              st_nxt.rw = st_r.shreg[0];
            end else begin
              st_nxt.phase = usw_pkg::USW_IDLE;
            end
          end
        end
        usw_pkg::USW_ACK_ADDR, usw_pkg::USW_RACK: begin
          st_nxt.bitcnt = usw_pkg::USW_BIT_ZERO;
          if (st_r.rw) begin
            st_nxt.phase = usw_pkg::USW_RDATA;
            st_nxt.shreg = status_byte;
            st_nxt.sda_oe = !status_byte[7];
          end else begin
            st_nxt.phase = usw_pkg::USW_WDATA;
            st_nxt.sda_oe = 1'b0;
          end
        end
        usw_pkg::USW_WDATA: begin
          if (st_r.bitcnt == usw_pkg::USW_BITS_BYTE) begin
            st_nxt.phase = usw_pkg::USW_ACK_WDATA;
            st_nxt.sda_oe = 1'b1;
          end
        end
        usw_pkg::USW_ACK_WDATA: begin
          st_nxt.phase = usw_pkg::USW_WDATA;
          st_nxt.bitcnt = usw_pkg::USW_BIT_ZERO;
          st_nxt.sda_oe = 1'b0;
        end
        usw_pkg::USW_RDATA: begin
          if (st_r.bitcnt == usw_pkg::USW_BITS_BYTE) begin
            st_nxt.phase = usw_pkg::USW_RACK;
            st_nxt.sda_oe = 1'b0;
          end else begin
            st_nxt.shreg = {st_r.shreg[6:0], 1'b0};
            st_nxt.sda_oe = !st_r.shreg[6];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // All paths open, factory outputs inactive, interrupt high at reset.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{phase: usw_pkg::USW_IDLE, bitcnt: usw_pkg::USW_BIT_ZERO,
                shreg: usw_pkg::USW_BYTE_ZERO, rw: 1'b0, sda_oe: 1'b0,
                scl_q: 1'b1, sda_q: 1'b1, id_q: 1'b0, att_q: 1'b0,
                pending: 1'b0, r_pusb: 1'b0, r_puart: 1'b0,
                r_sec: 1'b0, fac_o: 1'b0, fac_oe: !FACTORY_ACTIVE_LOW,
                boot: 1'b0, irq_n: 1'b1};
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign route_primary_usb = st_r.r_pusb;
  assign route_primary_uart = st_r.r_puart;
  assign route_secondary = st_r.r_sec;
  assign factory_cable_flag_out = st_r.fac_o;
  assign factory_cable_flag_oe = st_r.fac_oe;
  assign boot_sel_out = st_r.boot;
  assign irq_n_out = st_r.irq_n;
  assign i2c_sda_out = usw_pkg::USW_SDA_LOW;
  assign i2c_sda_oe = st_r.sda_oe;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_open_idle;
    clk_en && !manual_mode && acc_kind == usw_pkg::USW_ACC_NONE |=>
      !route_primary_usb && !route_primary_uart && !route_secondary;
  endproperty
  a_open_idle: assert property (p_open_idle)
    else $error("Path closed with nothing selected.");

  property p_man_uart;
    clk_en && manual_mode && manual_route == usw_pkg::USW_RT_PRI_UART |=>
      route_primary_uart && !route_primary_usb;
  endproperty
  a_man_uart: assert property (p_man_uart)
    else $error("Manual primary receive route not taken.");

  property p_man_usb;
    clk_en && manual_mode && manual_route == usw_pkg::USW_RT_PRI_USB |=>
      route_primary_usb && !route_primary_uart;
  endproperty
  a_man_usb: assert property (p_man_usb)
    else $error("Manual primary data route not taken.");

  property p_auto_usb;
    clk_en && !manual_mode && (acc_kind == usw_pkg::USW_ACC_USB ||
      acc_kind == usw_pkg::USW_ACC_USB_FACTORY) |=> route_primary_usb;
  endproperty
  a_auto_usb: assert property (p_auto_usb)
    else $error("USB accessory not routed to primary pair.");

  property p_auto_uart;
    clk_en && !manual_mode && acc_kind == usw_pkg::USW_ACC_UART_FACTORY |=>
      route_secondary;
  endproperty
  a_auto_uart: assert property (p_auto_uart)
    else $error("UART cable not routed to secondary pair.");

  // The interrupt registers the next pending value, so it falls one edge on.
  property p_id_event;
    clk_en && id_f != st_r.id_q && !int_mask |=> !irq_n_out;
  endproperty
  a_id_event: assert property (p_id_event)
    else $error("ID line change raised no interrupt.");

  // Each build drives the flag in its own manner, one edge after detection.
  property p_factory_drive;
    clk_en |=> factory_cable_flag_oe ==
      (FACTORY_ACTIVE_LOW ? $past(factory) : 1'b1) &&
      factory_cable_flag_out == (FACTORY_ACTIVE_LOW ? 1'b0 : $past(factory));
  endproperty
  a_factory_drive: assert property (p_factory_drive)
    else $error("Factory flag driven at wrong level.");

  property p_boot_low;
    clk_en && !factory |=> !boot_sel_out;
  endproperty
  a_boot_low: assert property (p_boot_low)
    else $error("Boot select high without factory cable.");

  property p_irq_assert;
    clk_en && attached != st_r.att_q && !int_mask |=> !irq_n_out;
  endproperty
  a_irq_assert: assert property (p_irq_assert)
    else $error("Attach change raised no interrupt.");

  property p_sda_phase;
    i2c_sda_oe |-> st_r.phase inside {usw_pkg::USW_ACK_ADDR,
      usw_pkg::USW_ACK_WDATA, usw_pkg::USW_RDATA};
  endproperty
  a_sda_phase: assert property (p_sda_phase)
    else $error("Data line driven outside acknowledge or read.");

  property p_masked;
    clk_en && int_mask |=> irq_n_out;
  endproperty
  a_masked: assert property (p_masked)
    else $error("Interrupt low while masked.");

  property p_exclusive;
    $onehot0({route_primary_usb, route_primary_uart, route_secondary});
  endproperty
  a_exclusive: assert property (p_exclusive)
    else $error("More than one host pair connected.");

  c_usb_route: cover property (route_primary_usb);
  c_sec_route: cover property (route_secondary);
  c_irq: cover property ($fell(irq_n_out));
  c_read: cover property (rd_done);

endmodule : usw_path_switch

`default_nettype wire

//--- verilog/usw_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none

module usw_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock, reset and enable.
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Raw pins and filtered result.
  input wire logic [W-1:0] pin_raw,
  output logic [W-1:0] pin_filt
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } usw_sync_t;

  usw_sync_t st_r;
  usw_sync_t st_nxt;

  // Shift the chain and accept a bit only when stages two and three agree.
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.filt[i] = st_r.s3[i];
      end
    end
  end

  // State register, frozen while the enable is low.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, filt: RST_VAL};
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign pin_filt = st_r.filt;

endmodule : usw_pin_sync

`default_nettype wire
